/* hdl/pie_periph_irq.sv */
// Module: peripheral interrupt enable register with flag gating toward the core
`timescale 1ns/1ps
//------------------------------------------------------------------------------
// Summary of operation
// RULE_01: Bit 6 enables the converter interrupt when 1 and blocks it when 0.
// RULE_02: Bit 3 enables the serial port interrupt when 1 and blocks it when 0.
// RULE_03: Bit 2 enables the first capture/compare unit interrupt when 1 and blocks it when 0.
// RULE_04: Bits 7, 5 and 4 are absent, read as zero and ignore writes.
// RULE_05: All present enable bits are read/write and clear to zero on reset.
// RULE_06: No peripheral interrupt reaches the core unless the group enable is also set.
// RULE_07: A peripheral flag sets on its event whatever the enables hold.
// RULE_08: Software should clear a flag before setting its enable.
// RULE_09: Bit 1 enables the timer-B match and bit 0 the timer-A overflow interrupt.
//------------------------------------------------------------------------------
module pie_periph_irq (
  // Clock and reset
  input  wire logic                       clk,
  input  wire logic                       nrst,
  // Register port
  input  wire logic [pie_pkg::ADDR_W-1:0] regAddr,
  input  wire logic [pie_pkg::DATA_W-1:0] regWdata,
  input  wire logic                       regWr,
  input  wire logic                       regRd,
  output logic      [pie_pkg::DATA_W-1:0] regRdata,
  // Peripheral events, one-cycle pulses
  input  wire logic                       adcDone,
  input  wire logic                       serialDone,
  input  wire logic                       capcmp1Event,
  input  wire logic                       timerBMatch,
  input  wire logic                       timerAOverflow,
  // Toward the core
  output logic                            periphIrq,
  output logic                            coreIrq,
  // Block interrupt
  output logic                            irq
);
  import pie_pkg::*;

  //----------------------------------------------------------------------------
  // State
  //----------------------------------------------------------------------------
  typedef struct packed {
    logic [7:0] enable;
    logic [7:0] control;
    logic [7:0] status;
    logic [7:0] mask;
    logic [7:0] rdata;
    logic       periphIrq;
    logic       coreIrq;
    logic       irq;
  } pie_state_s;

  pie_state_s st_ff;
  pie_state_s nxt_st;

  logic [7:0] flags;
  logic [7:0] events;
  logic       wrFlags;

  assign events  = {1'b0, adcDone, 2'b00, serialDone, capcmp1Event, timerBMatch, timerAOverflow};
  assign wrFlags = regWr && (regAddr == OFS_FLAGS);

  //----------------------------------------------------------------------------
  // Flags
  //----------------------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < DATA_W; gi++) begin : g_flag
      if (IMPL_MASK[gi]) begin : g_impl
        pie_flag_bit u_flag (
          .clk     (clk),
          .nrst    (nrst),
          .event_i (events[gi]),
          .wrEn    (wrFlags),
          .wrVal   (regWdata[gi]),
          .flag    (flags[gi])
        );
      end else begin : g_none
        assign flags[gi] = 1'b0;  // [RULE_04]
      end
    end
  endgenerate

  //----------------------------------------------------------------------------
  // Next state
  //----------------------------------------------------------------------------
  logic [7:0] pending;
  logic [7:0] stNext;

  always_comb begin
    nxt_st  = st_ff;
    pending = flags & st_ff.enable;  // [RULE_01] [RULE_02] [RULE_03] [RULE_09]
    stNext  = st_ff.status;
    nxt_st.rdata = 8'h00;
    if (regRd) begin
      case (regAddr)
        OFS_ENABLE:  nxt_st.rdata = st_ff.enable & IMPL_MASK;  // [RULE_04]
        OFS_FLAGS:   nxt_st.rdata = flags;
        OFS_CONTROL: nxt_st.rdata = st_ff.control;
        OFS_STATUS: begin
          nxt_st.rdata = st_ff.status;
          stNext       = 8'h00;
        end
        OFS_MASK:    nxt_st.rdata = st_ff.mask;
        default:     nxt_st.rdata = 8'h00;
      endcase
    end
    if (regWr) begin
      case (regAddr)
        OFS_ENABLE:  nxt_st.enable  = regWdata & IMPL_MASK;  // [RULE_04] [RULE_05]
        OFS_CONTROL: nxt_st.control = regWdata & CTRL_MASK;
        OFS_MASK:    nxt_st.mask    = regWdata & IMPL_MASK;
        default:     nxt_st.mask    = st_ff.mask;
      endcase
    end
    // New events set status even during a clearing read
    nxt_st.status = (stNext | events) & IMPL_MASK;
    // Group enable gates periphIrq and coreIrq; the status irq is not gated by it
    nxt_st.periphIrq = (|pending) && st_ff.control[BIT_GROUP_EN];  // [RULE_06]
    nxt_st.coreIrq   = (|pending) && st_ff.control[BIT_GROUP_EN] && st_ff.control[BIT_GLOBAL_EN];  // [RULE_06]
    nxt_st.irq       = |(nxt_st.status & st_ff.mask);
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      st_ff.enable    <= RST_ENABLE;  // [RULE_05]
      st_ff.control   <= RST_CONTROL;
      st_ff.status    <= RST_STATUS;
      st_ff.mask      <= RST_MASK;
      st_ff.rdata     <= 8'h00;
      st_ff.periphIrq <= 1'b0;
      st_ff.coreIrq   <= 1'b0;
      st_ff.irq       <= 1'b0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign regRdata  = st_ff.rdata;
  assign periphIrq = st_ff.periphIrq;
  assign coreIrq   = st_ff.coreIrq;
  assign irq       = st_ff.irq;

  //----------------------------------------------------------------------------
  // Checks
  //----------------------------------------------------------------------------
  sequence s_enWrite(int b);
    regWr && regAddr == OFS_ENABLE && regWdata[b];
  endsequence

  sequence s_enClear(int b);
    regWr && regAddr == OFS_ENABLE && !regWdata[b];
  endsequence

  property p_adc_en;
    @(posedge clk) disable iff (!nrst) s_enWrite(BIT_ADC) |=> st_ff.enable[BIT_ADC];
  endproperty
  a_adc_en: assert property (p_adc_en) else $error("adc enable not stored");  // [RULE_01]

  property p_serial_en;
    @(posedge clk) disable iff (!nrst) s_enWrite(BIT_SERIAL) |=> st_ff.enable[BIT_SERIAL];
  endproperty
  a_serial_en: assert property (p_serial_en) else $error("serial enable not stored");  // [RULE_02]

  property p_capcmp_en;
    @(posedge clk) disable iff (!nrst) s_enWrite(BIT_CAPCMP1) |=> st_ff.enable[BIT_CAPCMP1];
  endproperty
  a_capcmp_en: assert property (p_capcmp_en) else $error("capcmp enable not stored");  // [RULE_03]

  property p_unimpl;
    @(posedge clk) disable iff (!nrst) regRd && regAddr == OFS_ENABLE |=> (regRdata & ~IMPL_MASK) == 8'h00;
  endproperty
  a_unimpl: assert property (p_unimpl) else $error("unimplemented bits read nonzero");  // [RULE_04]

  property p_reset;
    @(posedge clk) !nrst |=> st_ff.enable == RST_ENABLE;
  endproperty
  a_reset: assert property (p_reset) else $error("enable not cleared by reset");  // [RULE_05]

  property p_group;
    @(posedge clk) disable iff (!nrst) !st_ff.control[BIT_GROUP_EN] |=> !periphIrq && !coreIrq;
  endproperty
  a_group: assert property (p_group) else $error("irq without group enable");  // [RULE_06]

  // Armed is judged in the cycle the flag shows, so a late enable write cannot race the check
  sequence s_adcArmed;
    st_ff.enable[BIT_ADC] && st_ff.control[BIT_GROUP_EN] && st_ff.control[BIT_GLOBAL_EN];
  endsequence

  property p_flag_any;
    @(posedge clk) disable iff (!nrst) adcDone |=> (flags[BIT_ADC] and (s_adcArmed |=> coreIrq));
  endproperty
  a_flag_any: assert property (p_flag_any) else $error("adc flag or request missing");  // [RULE_07]

  property p_timers;
    @(posedge clk) disable iff (!nrst) s_enWrite(BIT_TIMER_A) |=> st_ff.enable[BIT_TIMER_A];
  endproperty
  a_timers: assert property (p_timers) else $error("timer enable not stored");  // [RULE_09]

  property p_timer_b;
    @(posedge clk) disable iff (!nrst) s_enWrite(BIT_TIMER_B) |=> st_ff.enable[BIT_TIMER_B];
  endproperty
  a_timer_b: assert property (p_timer_b) else $error("timer-B enable not stored");  // [RULE_09]

  property p_adc_off;
    @(posedge clk) disable iff (!nrst) s_enClear(BIT_ADC) |=> !st_ff.enable[BIT_ADC];
  endproperty
  a_adc_off: assert property (p_adc_off) else $error("adc enable not cleared");  // [RULE_01]

  // A set flag with its enable off must stay silent toward the core
  property p_blocked;
    @(posedge clk) disable iff (!nrst) !(|(flags & st_ff.enable)) |=> !periphIrq;
  endproperty
  a_blocked: assert property (p_blocked) else $error("unenabled request");  // [RULE_01] [RULE_02] [RULE_03] [RULE_09]

  property p_core_req;
    @(posedge clk) disable iff (!nrst) (|(flags & st_ff.enable)) && st_ff.control[BIT_GROUP_EN]
      && st_ff.control[BIT_GLOBAL_EN] |=> coreIrq;
  endproperty
  a_core_req: assert property (p_core_req) else $error("armed request not raised");  // [RULE_06]

  property p_status_set;
    @(posedge clk) disable iff (!nrst) timerAOverflow |=> st_ff.status[BIT_TIMER_A];
  endproperty
  a_status_set: assert property (p_status_set) else $error("status not set by event");

  property p_rd_idle;
    @(posedge clk) disable iff (!nrst) !regRd |=> regRdata == 8'h00;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data outside read cycle");
endmodule : pie_periph_irq

/* hdl/pie_pkg.sv */
// Package: register map, field positions and reset values of the peripheral interrupt enable block
package pie_pkg;
  localparam int          DATA_W          = 8;
  localparam int          ADDR_W          = 9;
  localparam int          NUM_SRC         = 5;
  // Register offsets
  localparam logic [8:0]  OFS_ENABLE      = 9'h08C;  // periph_irq_enable_reg
  localparam logic [8:0]  OFS_FLAGS       = 9'h00C;  // Peripheral flag register
  localparam logic [8:0]  OFS_CONTROL     = 9'h00B;  // irq_control_reg
  localparam logic [8:0]  OFS_STATUS      = 9'h1F0;  // Sticky event status, clear on read
  localparam logic [8:0]  OFS_MASK        = 9'h1F1;  // Status mask
  // Field positions of the enable and flag registers
  localparam int          BIT_ADC         = 6;
  localparam int          BIT_SERIAL      = 3;
  localparam int          BIT_CAPCMP1     = 2;
  localparam int          BIT_TIMER_B     = 1;
  localparam int          BIT_TIMER_A     = 0;
  localparam logic [7:0]  IMPL_MASK       = 8'h4F;
  // Control register fields
  localparam int          BIT_GLOBAL_EN   = 7;
  localparam int          BIT_GROUP_EN    = 6;
  localparam logic [7:0]  CTRL_MASK       = 8'hC0;
  // Reset values
  localparam logic [7:0]  RST_ENABLE      = 8'h00;
  localparam logic [7:0]  RST_FLAGS       = 8'h00;
  localparam logic [7:0]  RST_CONTROL     = 8'h00;
  localparam logic [7:0]  RST_STATUS      = 8'h00;
  localparam logic [7:0]  RST_MASK        = 8'h00;
endpackage : pie_pkg

/* hdl/pie_flag_bit.sv */
// Module: one peripheral interrupt flag, set by its event, cleared by software
`timescale 1ns/1ps
module pie_flag_bit (
  // Clock and reset
  input  wire logic clk,
  input  wire logic nrst,
  // Event and software access
  input  wire logic event_i,
  input  wire logic wrEn,
  input  wire logic wrVal,
  // Flag
  output logic      flag
);
  import pie_pkg::*;

  typedef struct packed {
    logic flag;
  } pie_flag_s;

  pie_flag_s st_ff;
  pie_flag_s nxt_st;

  // Event wins over a software clear in the same cycle
  always_comb begin
    nxt_st = st_ff;
    if (wrEn) begin
      nxt_st.flag = wrVal;
    end
    if (event_i) begin
      nxt_st.flag = 1'b1;  // [RULE_07]
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign flag = st_ff.flag;

  property p_flag_set;
    @(posedge clk) disable iff (!nrst) event_i |=> flag;
  endproperty
  a_flag_set: assert property (p_flag_set) else $error("flag not set by event");  // [RULE_07]
endmodule : pie_flag_bit

/* tb/pie_event_src.sv */
// Partner model: peripheral event sources driving one-cycle event pulses
`timescale 1ns/1ps
module pie_event_src (
  // Clock
  input  wire logic       clk,
  // Events, indexed by enable bit position
  output logic      [7:0] evt
);
  initial evt = 8'h00;
  // Pulse of exactly one cycle, changed only at a rising edge
  task automatic pulse(input int idx);
    @(posedge clk);
    evt[idx] <= 1'b1;
    @(posedge clk);
    evt <= 8'h00;
  endtask : pulse
endmodule : pie_event_src

/* tb/pie_periph_irq_tb_top.sv */
// Testbench: peripheral interrupt enable block with its event sources
`timescale 1ns/1ps
module pie_periph_irq_tb_top;
  import pie_pkg::*;
  logic              clk, nrst, regWr, regRd, periphIrq, coreIrq, irq;
  logic [ADDR_W-1:0] regAddr;
  logic [DATA_W-1:0] regWdata, regRdata, d, b;
  logic [7:0]        evt;
  int                n_mismatch = 0;
  int                cmp_count = 0;
  int                cyc = 0;
  int                srcBit[5] = '{BIT_ADC, BIT_SERIAL, BIT_CAPCMP1, BIT_TIMER_B, BIT_TIMER_A};

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  pie_periph_irq dut (.clk(clk), .nrst(nrst), .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr),
    .regRd(regRd), .regRdata(regRdata), .adcDone(evt[BIT_ADC]), .serialDone(evt[BIT_SERIAL]),
    .capcmp1Event(evt[BIT_CAPCMP1]), .timerBMatch(evt[BIT_TIMER_B]), .timerAOverflow(evt[BIT_TIMER_A]),
    .periphIrq(periphIrq), .coreIrq(coreIrq), .irq(irq));
  pie_event_src src (.clk(clk), .evt(evt));

  function automatic logic [7:0] expEn(input logic [7:0] w);
    return w & IMPL_MASK;
  endfunction : expEn

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected %s: expected %0h seen %0h", what, exp, got);
    end
  endtask : chk

  task automatic wr(input logic [8:0] a, input logic [7:0] v);
    @(posedge clk);
    regAddr  <= a;
    regWdata <= v;
    regWr    <= 1'b1;
    @(posedge clk);
    regWr    <= 1'b0;
  endtask : wr

  task automatic rdChk(input string what, input logic [8:0] a, input logic [7:0] exp);
    @(posedge clk);
    regAddr <= a;
    regRd   <= 1'b1;
    @(posedge clk);
    regRd   <= 1'b0;
    #1;
    chk(what, exp, regRdata);
  endtask : rdChk

  // Outputs are registered, so settle on an edge plus a little
  task automatic settle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : settle

  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : print_verdict

  // Hang guard, far above the few hundred cycles the tests need
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      n_mismatch++;
      print_verdict();
    end
  end

  initial begin
    nrst = 1'b0;
    regWr = 1'b0;
    regRd = 1'b0;
    regAddr = '0;
    regWdata = '0;
    void'($urandom(74472));
    repeat (12) @(posedge clk);
    nrst <= 1'b1;
    rdChk("enable", OFS_ENABLE, RST_ENABLE);
    rdChk("control", OFS_CONTROL, RST_CONTROL);
    $display("test reset values done");
    for (int i = 0; i < 20; i++) begin
      d = (i == 0) ? 8'hFF : (i == 1) ? 8'h00 : 8'($urandom);
      wr(OFS_ENABLE, d);
      rdChk("enable", OFS_ENABLE, expEn(d));
    end
    $display("test enable access done");
    wr(OFS_MASK, 8'hFF);
    rdChk("mask", OFS_MASK, IMPL_MASK);
    foreach (srcBit[k]) begin
      b = 8'h01 << srcBit[k];
      wr(OFS_FLAGS, 8'h00);
      wr(OFS_CONTROL, 8'h00);
      wr(OFS_ENABLE, 8'h00);
      src.pulse(srcBit[k]);
      settle(2);
      chk("periphIrq blocked", 8'h00, {7'h00, periphIrq});
      rdChk("flags", OFS_FLAGS, b);
      wr(OFS_ENABLE, b);
      settle(2);
      chk("periphIrq group off", 8'h00, {7'h00, periphIrq});
      wr(OFS_CONTROL, 8'h40);
      settle(2);
      chk("periphIrq", 8'h01, {7'h00, periphIrq});
      chk("coreIrq global off", 8'h00, {7'h00, coreIrq});
      wr(OFS_CONTROL, 8'hC0);
      settle(2);
      chk("coreIrq", 8'h01, {7'h00, coreIrq});
      wr(OFS_ENABLE, ~b);
      settle(2);
      chk("periphIrq disabled", 8'h00, {7'h00, periphIrq});
    end
    $display("test sources done");
    chk("irq", 8'h01, {7'h00, irq});
    rdChk("status", OFS_STATUS, IMPL_MASK);
    settle(1);
    chk("irq cleared", 8'h00, {7'h00, irq});
    wr(OFS_MASK, 8'h00);
    src.pulse(BIT_TIMER_A);
    settle(2);
    chk("irq masked", 8'h00, {7'h00, irq});
    rdChk("status", OFS_STATUS, 8'h01);
    rdChk("unmapped", 9'h1FF, 8'h00);
    $display("test status and mask done");
    wr(OFS_FLAGS, 8'h00);
    wr(OFS_CONTROL, 8'hFF);
    rdChk("control", OFS_CONTROL, CTRL_MASK);
    wr(OFS_ENABLE, 8'hFF);
    src.pulse(BIT_ADC);
    settle(2);
    chk("coreIrq armed", 8'h01, {7'h00, coreIrq});
    wr(OFS_FLAGS, 8'hFF);
    rdChk("flags", OFS_FLAGS, IMPL_MASK);
    @(posedge clk);
    nrst <= 1'b0;
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    rdChk("enable after reset", OFS_ENABLE, RST_ENABLE);
    rdChk("flags after reset", OFS_FLAGS, RST_FLAGS);
    chk("coreIrq after reset", 8'h00, {7'h00, coreIrq});
    $display("test armed request and reset done");
    print_verdict();
  end
endmodule : pie_periph_irq_tb_top
